// [src/snp_receiver.sv]
`timescale 1ns/1ps
module snp_receiver #(
  parameter int BIT_CYC = snp_pkg::BIT_CYCLES,
  parameter int SEC_CYC = snp_pkg::SEC_CYCLES,
  parameter int PULSE_CYC = snp_pkg::PULSE_CYCLES,
  parameter int SLOT_CYC = snp_pkg::FIX_SLOT_CYCLES,
  parameter longint ALM_CYC = snp_pkg::ALMANAC_CYCLES,
  parameter int BOOT_CYC = snp_pkg::BOOT_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic main_pwr_ok,
  input wire logic backup_pwr_ok,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_fix_rate,
  input wire logic utc_second,
  input wire logic fix_3d_valid,
  input wire logic eph_update,
  input wire logic rxd_in,
  input wire logic rxd_driven,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic txd,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_frame_err,
  output logic second_tick_pulse,
  output logic fix_tick,
  output logic [3:0] fix_rate,
  output snp_pkg::snp_mode_t mode,
  output logic almanac_collect,
  output logic eph_valid,
  output logic [31:0] rtc_seconds
);

  typedef struct packed {
    snp_pkg::snp_mode_t mode;
    logic [31:0] boot_cnt;
    logic [39:0] alm_cnt;
    logic [31:0] sec_cnt;
    logic [31:0] rtc_sec;
    logic [31:0] slot_cnt;
    logic [4:0] fix_acc;
    logic [3:0] fix_rate;
    logic fix_tick;
    logic [31:0] pulse_cnt;
    logic pulse;
    logic eph_valid;
    logic cfg_lost;
    logic alm_collect;
    snp_pkg::snp_ser_t rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_err;
    snp_pkg::snp_ser_t tx_st;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic txd;
    logic tx_ready;
  } snp_state_t;

  snp_state_t state_reg;
  snp_state_t state_next;

  logic rx_line;

  function automatic logic is_nav(input snp_pkg::snp_mode_t m);
    is_nav = (m == snp_pkg::MODE_TRACK) || (m == snp_pkg::MODE_LPTRACK);
  endfunction

  // Undriven receive line reads as the pull-up level
  assign rx_line = rxd_driven ? rxd_in : 1'b1;

  always_comb begin
    state_next = state_reg;
    state_next.fix_tick = 1'b0;
    state_next.rx_valid = 1'b0;
    state_next.rx_err = 1'b0;

    // Real-time clock keeps running on the backup supply alone
    if (!backup_pwr_ok) begin
      state_next.cfg_lost = 1'b1;
      state_next.eph_valid = 1'b0;
      state_next.rtc_sec = 32'h0;
      state_next.sec_cnt = 32'h0;
    end else if (state_reg.sec_cnt == 32'(SEC_CYC - 1)) begin
      state_next.sec_cnt = 32'h0;
      state_next.rtc_sec = state_reg.rtc_sec + 32'h1;
    end else begin
      state_next.sec_cnt = state_reg.sec_cnt + 32'h1;
    end

    case (state_reg.mode)
      snp_pkg::MODE_BOOT: begin
        if (state_reg.boot_cnt == 32'(BOOT_CYC - 1)) begin
          state_next.mode = snp_pkg::MODE_TRACK;
          state_next.alm_cnt = 40'h0;
          state_next.alm_collect = 1'b1;
        end else begin
          state_next.boot_cnt = state_reg.boot_cnt + 32'h1;
        end
        if (state_reg.cfg_lost && backup_pwr_ok) begin
          state_next.fix_rate = snp_pkg::FIX_RATE_RESET;
          state_next.cfg_lost = 1'b0;
        end
      end
      snp_pkg::MODE_TRACK: begin
        if (state_reg.alm_cnt == 40'(ALM_CYC - 1)) begin
          state_next.mode = snp_pkg::MODE_LPTRACK;
          state_next.alm_collect = 1'b0;
        end else begin
          state_next.alm_cnt = state_reg.alm_cnt + 40'h1;
        end
      end
      snp_pkg::MODE_LPTRACK: begin
        state_next.alm_collect = 1'b0;
      end
      snp_pkg::MODE_BACKUP: begin
        if (main_pwr_ok) begin
          state_next.mode = snp_pkg::MODE_BOOT;
          state_next.boot_cnt = 32'h0;
        end
      end
      default: begin
        state_next.mode = snp_pkg::MODE_BOOT;
      end
    endcase

    // Ephemeris and user settings are untouched here so they outlive the main supply
    if (!main_pwr_ok) begin
      state_next.mode = snp_pkg::MODE_BACKUP;
      state_next.alm_collect = 1'b0;
      state_next.pulse = 1'b0;
      state_next.pulse_cnt = 32'h0;
      state_next.slot_cnt = 32'h0;
      state_next.fix_acc = 5'h0;
      state_next.rx_st = snp_pkg::SER_IDLE;
      state_next.tx_st = snp_pkg::SER_IDLE;
      state_next.txd = 1'b1;
      state_next.tx_ready = 1'b0;
    end

    if (is_nav(state_reg.mode) && main_pwr_ok) begin
      if (eph_update && backup_pwr_ok) begin
        state_next.eph_valid = 1'b1;
      end
      // Out-of-range rates are ignored rather than clamped
      if (cfg_wr && cfg_fix_rate != 4'h0 && cfg_fix_rate <= snp_pkg::FIX_RATE_LIMIT) begin
        state_next.fix_rate = cfg_fix_rate;
      end
      // Rate accumulator over tenth-second slots gives every rate 1..10 exactly on average
      if (state_reg.slot_cnt == 32'(SLOT_CYC - 1)) begin
        state_next.slot_cnt = 32'h0;
        if (5'(state_reg.fix_acc + 5'(state_reg.fix_rate)) >= 5'(snp_pkg::FIX_RATE_MAX_HZ)) begin
          state_next.fix_tick = 1'b1;
          state_next.fix_acc = 5'(state_reg.fix_acc + 5'(state_reg.fix_rate)
                               - 5'(snp_pkg::FIX_RATE_MAX_HZ));
        end else begin
          state_next.fix_acc = 5'(state_reg.fix_acc + 5'(state_reg.fix_rate));
        end
      end else begin
        state_next.slot_cnt = state_reg.slot_cnt + 32'h1;
      end

      // Pulse starts on the reference edge itself, one register stage of latency
      if (utc_second && fix_3d_valid) begin
        state_next.pulse = 1'b1;
        state_next.pulse_cnt = 32'h0;
      end else if (state_reg.pulse) begin
        if (!fix_3d_valid || state_reg.pulse_cnt == 32'(PULSE_CYC - 1)) begin
          state_next.pulse = 1'b0;
        end else begin
          state_next.pulse_cnt = state_reg.pulse_cnt + 32'h1;
        end
      end

      case (state_reg.rx_st)
        snp_pkg::SER_IDLE: begin
          if (!rx_line) begin
            state_next.rx_st = snp_pkg::SER_START;
            state_next.rx_cnt = 16'(BIT_CYC / 2);
          end
        end
        snp_pkg::SER_START: begin
          if (state_reg.rx_cnt != 16'h0) begin
            state_next.rx_cnt = state_reg.rx_cnt - 16'h1;
          end else if (rx_line) begin
            state_next.rx_st = snp_pkg::SER_IDLE;
          end else begin
            state_next.rx_st = snp_pkg::SER_DATA;
            state_next.rx_cnt = 16'(BIT_CYC - 1);
            state_next.rx_bit = 3'h0;
          end
        end
        snp_pkg::SER_DATA: begin
          if (state_reg.rx_cnt != 16'h0) begin
            state_next.rx_cnt = state_reg.rx_cnt - 16'h1;
          end else begin
            state_next.rx_sh = {rx_line, state_reg.rx_sh[7:1]};
            state_next.rx_cnt = 16'(BIT_CYC - 1);
            state_next.rx_bit = state_reg.rx_bit + 3'h1;
            if (state_reg.rx_bit == snp_pkg::LAST_DATA_BIT) begin
              state_next.rx_st = snp_pkg::SER_STOP;
            end
          end
        end
        snp_pkg::SER_STOP: begin
          if (state_reg.rx_cnt != 16'h0) begin
            state_next.rx_cnt = state_reg.rx_cnt - 16'h1;
          end else begin
            state_next.rx_st = snp_pkg::SER_IDLE;
            if (rx_line) begin
              state_next.rx_data = state_reg.rx_sh;
              state_next.rx_valid = 1'b1;
            end else begin
              state_next.rx_err = 1'b1;
            end
          end
        end
        default: begin
          state_next.rx_st = snp_pkg::SER_IDLE;
        end
      endcase

      case (state_reg.tx_st)
        snp_pkg::SER_IDLE: begin
          state_next.txd = 1'b1;
          state_next.tx_ready = 1'b1;
          if (tx_valid && state_reg.tx_ready) begin
            state_next.tx_st = snp_pkg::SER_START;
            state_next.tx_sh = tx_data;
            state_next.txd = 1'b0;
            state_next.tx_cnt = 16'(BIT_CYC - 1);
            state_next.tx_ready = 1'b0;
          end
        end
        snp_pkg::SER_START: begin
          if (state_reg.tx_cnt != 16'h0) begin
            state_next.tx_cnt = state_reg.tx_cnt - 16'h1;
          end else begin
            state_next.tx_st = snp_pkg::SER_DATA;
            state_next.txd = state_reg.tx_sh[0];
            state_next.tx_bit = 3'h0;
            state_next.tx_cnt = 16'(BIT_CYC - 1);
          end
        end
        snp_pkg::SER_DATA: begin
          if (state_reg.tx_cnt != 16'h0) begin
            state_next.tx_cnt = state_reg.tx_cnt - 16'h1;
          end else begin
            state_next.tx_cnt = 16'(BIT_CYC - 1);
            if (state_reg.tx_bit == snp_pkg::LAST_DATA_BIT) begin
              state_next.tx_st = snp_pkg::SER_STOP;
              state_next.txd = 1'b1;
            end else begin
              state_next.tx_bit = state_reg.tx_bit + 3'h1;
              state_next.tx_sh = {1'b0, state_reg.tx_sh[7:1]};
              state_next.txd = state_reg.tx_sh[1];
            end
          end
        end
        snp_pkg::SER_STOP: begin
          if (state_reg.tx_cnt != 16'h0) begin
            state_next.tx_cnt = state_reg.tx_cnt - 16'h1;
          end else begin
            state_next.tx_st = snp_pkg::SER_IDLE;
            state_next.tx_ready = 1'b1;
          end
        end
        default: begin
          state_next.tx_st = snp_pkg::SER_IDLE;
        end
      endcase
    end else if (main_pwr_ok) begin
      // Still booting: line held idle, no traffic taken
      state_next.txd = 1'b1;
      state_next.tx_ready = 1'b0;
      state_next.pulse = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.mode <= snp_pkg::MODE_BOOT;
      state_reg.fix_rate <= snp_pkg::FIX_RATE_RESET;
      state_reg.rx_st <= snp_pkg::SER_IDLE;
      state_reg.tx_st <= snp_pkg::SER_IDLE;
      state_reg.txd <= 1'b1;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign tx_ready = state_reg.tx_ready;
  assign txd = state_reg.txd;
  assign rx_data = state_reg.rx_data;
  assign rx_valid = state_reg.rx_valid;
  assign rx_frame_err = state_reg.rx_err;
  assign second_tick_pulse = state_reg.pulse;
  assign fix_tick = state_reg.fix_tick;
  assign fix_rate = state_reg.fix_rate;
  assign mode = state_reg.mode;
  assign almanac_collect = state_reg.alm_collect;
  assign eph_valid = state_reg.eph_valid;
  assign rtc_seconds = state_reg.rtc_sec;

endmodule

// [src/snp_pkg.sv]
// Summary of operation
// - Each serial character carries eight data bits, no parity, one stop bit.
// - After factory power-up the serial port runs at 9600 baud.
// - One position fix per second by default, configurable up to ten per second.
// - On power-up the program loads from internal flash before normal operation.
// - Tracking mode gathers almanac, then moves to low-power tracking after twelve minutes.
// - Low-power tracking keeps navigating but stops gathering almanac data.
// - Removing main supply enters backup mode; the real-time clock keeps counting.
// - Backup mode keeps ephemeris so a quick first fix follows power return.
// - User settings survive main supply loss while the backup supply stays up.
// - Losing the backup supply restores factory settings on next power-up.
// - Serial input comes on the receive line, pulled high when undriven.
// - Serial output with navigation sentences goes out on the transmit line.
// - Timing pulse edge aligns with the time reference within fifty nanoseconds RMS.
// - Timing pulse lasts 100 ms, rises on the UTC second, only with 3D fix.
package snp_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int DATA_BITS = 8;
  localparam int BAUD_DEFAULT = 9600;
  // Nearest whole cycle; the 0.003 % baud error is far inside the UART margin
  localparam int BIT_CYCLES = (CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT;
  localparam int HALF_BIT_CYCLES = BIT_CYCLES / 2;

  localparam int SEC_CYCLES = CLK_HZ;
  localparam int PULSE_WIDTH_MS = 100;
  localparam int PULSE_CYCLES = (CLK_HZ / 1000) * PULSE_WIDTH_MS;

  localparam int FIX_RATE_DEFAULT_HZ = 1;
  localparam int FIX_RATE_MAX_HZ = 10;
  localparam int FIX_SLOT_CYCLES = CLK_HZ / FIX_RATE_MAX_HZ;

  localparam int ALMANAC_MINUTES = 12;
  localparam longint ALMANAC_CYCLES = 64'(CLK_HZ) * 64'd60 * 64'(ALMANAC_MINUTES);

  // Flash load time is not fixed by the device; plain default
  localparam int BOOT_CYCLES = 1000;

  localparam logic [3:0] FIX_RATE_RESET = 4'(FIX_RATE_DEFAULT_HZ);
  localparam logic [3:0] FIX_RATE_LIMIT = 4'(FIX_RATE_MAX_HZ);
  localparam logic [2:0] LAST_DATA_BIT = 3'(DATA_BITS - 1);

  typedef enum logic [1:0] {
    MODE_BOOT = 2'h0,
    MODE_TRACK = 2'h1,
    MODE_LPTRACK = 2'h2,
    MODE_BACKUP = 2'h3
  } snp_mode_t;

  typedef enum logic [1:0] {
    SER_IDLE = 2'h0,
    SER_START = 2'h1,
    SER_DATA = 2'h2,
    SER_STOP = 2'h3
  } snp_ser_t;

endpackage

// [verif/snp_receiver_sva.sv]
`timescale 1ns/1ps
module snp_receiver_sva #(
  parameter int BIT_CYC = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic main_pwr_ok,
  input wire logic backup_pwr_ok,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_fix_rate,
  input wire logic utc_second,
  input wire logic fix_3d_valid,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic txd,
  input wire logic rx_valid,
  input wire logic rx_frame_err,
  input wire logic second_tick_pulse,
  input wire logic [3:0] fix_rate,
  input wire snp_pkg::snp_mode_t mode,
  input wire logic almanac_collect,
  input wire logic eph_valid,
  input wire logic [31:0] rtc_seconds
);
  localparam int STOP_DLY = 9 * BIT_CYC + 1;
  localparam int READY_DLY = 10 * BIT_CYC + 1;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic nav;
  assign nav = main_pwr_ok && (mode == snp_pkg::MODE_TRACK || mode == snp_pkg::MODE_LPTRACK);
  sequence s_take;
    tx_valid && tx_ready && clk_en && main_pwr_ok;
  endsequence
  sequence s_hold;
    fix_3d_valid && !utc_second && main_pwr_ok;
  endsequence
  sequence s_pulse_run;
    $rose(second_tick_pulse) ##0 s_hold[*8] ##1 s_hold;
  endsequence
  // Power loss mid-frame legally cuts the frame short
  a_tx_start: assert property (disable iff (rst || !main_pwr_ok) s_take |=> (!txd && !tx_ready)[*8])
    else $error("start bit not low for a bit time");
  a_tx_stop: assert property (disable iff (rst || !main_pwr_ok) s_take |-> ##STOP_DLY (txd && !tx_ready))
    else $error("stop bit missing");
  a_tx_ready: assert property (disable iff (rst || !main_pwr_ok) s_take |-> ##READY_DLY tx_ready)
    else $error("frame length wrong");
  a_pulse_start: assert property (utc_second && fix_3d_valid && nav |=> second_tick_pulse)
    else $error("timing pulse not raised");
  a_pulse_width: assert property (s_pulse_run |=> second_tick_pulse ##1 (!second_tick_pulse || $past(utc_second)))
    else $error("timing pulse width wrong");
  a_pulse_nofix: assert property (!fix_3d_valid |=> !second_tick_pulse)
    else $error("timing pulse without fix");
  a_alm_mode: assert property (almanac_collect == (mode == snp_pkg::MODE_TRACK))
    else $error("almanac flag disagrees with mode");
  a_backup_enter: assert property (!main_pwr_ok |=> mode == snp_pkg::MODE_BACKUP)
    else $error("backup mode not entered");
  a_backup_loss: assert property (!backup_pwr_ok |=> !eph_valid && rtc_seconds == 32'h0)
    else $error("retained state survived backup loss");
  a_cfg_write: assert property (cfg_wr && nav && cfg_fix_rate != 4'h0 && cfg_fix_rate <= 4'hA
    |=> fix_rate == $past(cfg_fix_rate))
    else $error("fix rate not written");
  a_boot_seq: assert property ($fell(rst) && main_pwr_ok && backup_pwr_ok
    |-> mode == snp_pkg::MODE_BOOT ##[1:5] mode == snp_pkg::MODE_TRACK)
    else $error("boot sequence wrong");
  a_rx_pulse: assert property (rx_valid || rx_frame_err |-> !(rx_valid && rx_frame_err) ##1 !(rx_valid || rx_frame_err))
    else $error("receive status pulse wrong");
endmodule

bind snp_receiver snp_receiver_sva #(.BIT_CYC(BIT_CYC)) i_snp_receiver_sva (.core_clk(core_clk),
  .rst(rst), .clk_en(clk_en), .main_pwr_ok(main_pwr_ok), .backup_pwr_ok(backup_pwr_ok),
  .cfg_wr(cfg_wr), .cfg_fix_rate(cfg_fix_rate), .utc_second(utc_second), .fix_3d_valid(fix_3d_valid),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .txd(txd), .rx_valid(rx_valid), .rx_frame_err(rx_frame_err),
  .second_tick_pulse(second_tick_pulse), .fix_rate(fix_rate), .mode(mode),
  .almanac_collect(almanac_collect), .eph_valid(eph_valid), .rtc_seconds(rtc_seconds));

// [verif/snp_host.sv]
`timescale 1ns/1ps
module snp_host #(
  parameter int BIT_CYC = 8
) (
  input wire logic core_clk,
  input wire logic txd,
  output logic rxd_in,
  output logic rxd_driven,
  output logic [7:0] got_data,
  output logic got_stop,
  output int got_cnt
);
  // Undriven line shows the wrong level so only the pull-up can make it idle
  initial begin
    rxd_in = 1'h0;
    rxd_driven = 1'h0;
    got_data = 8'h00;
    got_stop = 1'h0;
    got_cnt = 0;
  end
  task automatic send_byte(input logic [7:0] data, input logic stop);
    logic [9:0] frame;
    frame = {stop, data, 1'h0};
    rxd_driven <= 1'h1;
    for (int i = 0; i < 10; i++) begin
      rxd_in <= frame[i];
      repeat (BIT_CYC) @(posedge core_clk);
    end
    rxd_driven <= 1'h0;
    rxd_in <= ~frame[9];
  endtask
  // Samples each bit at its middle, LSB first
  always begin
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge core_clk);
      got_data[i] = txd;
    end
    repeat (BIT_CYC) @(posedge core_clk);
    got_stop = txd;
    got_cnt++;
  end
endmodule

// [verif/snp_receiver_tb.sv]
`timescale 1ns/1ps
module snp_receiver_tb;
  logic core_clk, rst, main_pwr_ok, backup_pwr_ok, cfg_wr, utc_second, fix_3d_valid, eph_update;
  logic rxd_in, rxd_driven, tx_valid, tx_ready, txd, rx_valid, rx_frame_err, second_tick_pulse;
  logic fix_tick, almanac_collect, eph_valid, got_stop, clk_en;
  logic [3:0] cfg_fix_rate, fix_rate;
  logic [7:0] tx_data, rx_data, got_data;
  logic [31:0] rtc_seconds;
  snp_pkg::snp_mode_t mode;
  int got_cnt, err_total, n_tests;
  int cyc = 0;
  // Shortened timing so every mode is reached within a short run
  localparam int TB_BIT_CYC = 8;
  localparam int TB_SEC_CYC = 50;
  localparam int TB_PULSE_CYC = 10;
  localparam int TB_SLOT_CYC = 5;
  localparam longint TB_ALM_CYC = 200;
  localparam int TB_BOOT_CYC = 4;
  snp_receiver #(.BIT_CYC(TB_BIT_CYC), .SEC_CYC(TB_SEC_CYC), .PULSE_CYC(TB_PULSE_CYC),
    .SLOT_CYC(TB_SLOT_CYC), .ALM_CYC(TB_ALM_CYC), .BOOT_CYC(TB_BOOT_CYC)) i_snp_receiver (
    .core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .main_pwr_ok(main_pwr_ok), .backup_pwr_ok(backup_pwr_ok), .cfg_wr(cfg_wr),
    .cfg_fix_rate(cfg_fix_rate), .utc_second(utc_second), .fix_3d_valid(fix_3d_valid),
    .eph_update(eph_update), .rxd_in(rxd_in), .rxd_driven(rxd_driven), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .txd(txd), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_frame_err(rx_frame_err), .second_tick_pulse(second_tick_pulse), .fix_tick(fix_tick),
    .fix_rate(fix_rate), .mode(mode), .almanac_collect(almanac_collect), .eph_valid(eph_valid),
    .rtc_seconds(rtc_seconds));
  snp_host #(.BIT_CYC(TB_BIT_CYC)) i_snp_host (.core_clk(core_clk), .txd(txd), .rxd_in(rxd_in),
    .rxd_driven(rxd_driven), .got_data(got_data), .got_stop(got_stop), .got_cnt(got_cnt));
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %0h", $time, what, got);
    end
  endtask
  task automatic wait_mode(input snp_pkg::snp_mode_t m);
    for (int k = 0; k < 300 && mode !== m; k++) @(negedge core_clk);
  endtask
  task automatic wr_cfg(input logic [3:0] r);
    @(posedge core_clk);
    cfg_fix_rate <= r;
    cfg_wr <= 1'h1;
    @(posedge core_clk);
    cfg_wr <= 1'h0;
    @(negedge core_clk);
  endtask
  task automatic count_on(input int len, ref logic sig, output int n);
    n = 0;
    repeat (len) begin
      @(posedge core_clk);
      n += (sig === 1'h1);
    end
  endtask
  task automatic t_boot();
    @(negedge core_clk);
    chk({mode, txd, tx_ready, fix_rate}, {snp_pkg::MODE_BOOT, 6'h21}, "reset state");
    wait_mode(snp_pkg::MODE_TRACK);
    chk({mode, almanac_collect}, {snp_pkg::MODE_TRACK, 1'h1}, "track");
    wait_mode(snp_pkg::MODE_LPTRACK);
    chk({mode, almanac_collect}, {snp_pkg::MODE_LPTRACK, 1'h0}, "low power");
  endtask
  // Holds the request until ready is sampled high; caller releases valid
  task automatic tx_byte(input logic [7:0] b);
    int k;
    tx_data <= b;
    tx_valid <= 1'h1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (tx_ready !== 1'h1 && k < 200);
  endtask
  task automatic t_tx();
    @(posedge core_clk);
    tx_byte(8'h80);
    tx_byte(8'h35);
    tx_valid <= 1'h0;
    chk({got_data, got_stop}, {8'h80, 1'h1}, "first frame");
    repeat (90) @(posedge core_clk);
    chk({got_cnt[7:0], got_data, got_stop}, {8'h02, 8'h35, 1'h1}, "second frame");
  endtask
  task automatic wait_rx(output logic v, output logic e);
    v = 1'h0;
    e = 1'h0;
    for (int k = 0; k < 150 && !v && !e; k++) begin
      @(posedge core_clk);
      v = rx_valid;
      e = rx_frame_err;
    end
  endtask
  task automatic t_rx();
    logic v, e;
    @(posedge core_clk);
    fork
      i_snp_host.send_byte(8'h4B, 1'h1);
      wait_rx(v, e);
    join
    chk({v, e, rx_data}, {2'h2, 8'h4B}, "good byte");
    @(posedge core_clk);
    fork
      i_snp_host.send_byte(8'hE1, 1'h0);
      wait_rx(v, e);
    join
    chk({v, e, rx_data}, {2'h1, 8'h4B}, "bad stop");
  endtask
  task automatic t_pulse(input logic fix, input int exp);
    int n;
    @(posedge core_clk);
    fix_3d_valid <= fix;
    utc_second <= 1'h1;
    @(posedge core_clk);
    utc_second <= 1'h0;
    count_on(20, second_tick_pulse, n);
    chk(n, exp, "pulse length");
  endtask
  task automatic t_cfg();
    int n;
    count_on(100, fix_tick, n);
    chk(n, 2, "default ticks");
    wr_cfg(4'hA);
    wr_cfg(4'hB);
    chk(fix_rate, 4'hA, "rate limit");
    count_on(100, fix_tick, n);
    chk(n, 20, "ticks at ten");
  endtask
  task automatic t_backup();
    wr_cfg(4'h3);
    @(posedge core_clk);
    eph_update <= 1'h1;
    @(posedge core_clk);
    eph_update <= 1'h0;
    main_pwr_ok <= 1'h0;
    repeat (2) @(negedge core_clk);
    chk({mode, tx_ready, eph_valid}, {snp_pkg::MODE_BACKUP, 2'h1}, "backup");
    chk(rtc_seconds != 32'h0, 1'h1, "clock kept");
    @(posedge core_clk);
    main_pwr_ok <= 1'h1;
    wait_mode(snp_pkg::MODE_TRACK);
    chk({fix_rate, eph_valid}, {4'h3, 1'h1}, "settings kept");
    @(posedge core_clk);
    {main_pwr_ok, backup_pwr_ok} <= 2'h0;
    repeat (3) @(posedge core_clk);
    {main_pwr_ok, backup_pwr_ok} <= 2'h3;
    wait_mode(snp_pkg::MODE_TRACK);
    chk({fix_rate, eph_valid}, {4'h1, 1'h0}, "factory restore");
  endtask
  // Low enable must hold every register, the seconds count included
  task automatic t_freeze();
    logic [31:0] r;
    @(posedge core_clk);
    clk_en <= 1'h0;
    @(negedge core_clk);
    r = rtc_seconds;
    repeat (60) @(posedge core_clk);
    @(negedge core_clk);
    chk(rtc_seconds, r, "frozen clock");
    @(posedge core_clk);
    clk_en <= 1'h1;
    repeat (TB_SEC_CYC) @(posedge core_clk);
    @(negedge core_clk);
    chk(rtc_seconds, r + 32'h1, "clock resumed");
  endtask
  initial begin
    rst = 1'h1;
    {main_pwr_ok, backup_pwr_ok} = 2'h3;
    {cfg_wr, utc_second, fix_3d_valid, eph_update, tx_valid} = 5'h00;
    cfg_fix_rate = 4'h1;
    clk_en = 1'h1;
    tx_data = 8'h00;
    err_total = 0;
    n_tests = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    t_boot();
    t_tx();
    t_rx();
    t_pulse(1'h1, TB_PULSE_CYC);
    t_pulse(1'h0, 0);
    t_cfg();
    t_backup();
    t_freeze();
    print_verdict();
  end
endmodule
